// ==== rtl/pmcs_regs.vh ====
`ifndef PMCS_REGS_VH
`define PMCS_REGS_VH
// Register byte addresses (word aligned)
`define PMCS_ADDR_CTRL_ONE 4'h0
`define PMCS_ADDR_CTRL_TWO 4'h4
`define PMCS_ADDR_STATUS 4'h8
`define PMCS_ADDR_SLEEP_CMD 4'hc
// Control one field positions
`define PMCS_STBY_SEL_BIT 7
`define PMCS_WAIT_HI_BIT 6
`define PMCS_WAIT_LO_BIT 4
`define PMCS_SAMPLE_RATE_BIT 3
`define PMCS_ONE_WMASK 8'hf8
// Control two field positions
`define PMCS_SLEEP_KIND_BIT 7
`define PMCS_LOW_SPEED_BIT 6
`define PMCS_DIRECT_BIT 5
`define PMCS_ACT_DIV_HI_BIT 4
`define PMCS_ACT_DIV_LO_BIT 2
`define PMCS_SUB_DIV_HI_BIT 1
`define PMCS_SUB_DIV_LO_BIT 0
// Reset values
`define PMCS_ONE_RESET 8'h00
`define PMCS_TWO_RESET 8'h00
// Mode encodings
`define PMCS_MODE_ACTIVE 3'h0
`define PMCS_MODE_SLEEP 3'h1
`define PMCS_MODE_SUBACTIVE 3'h2
`define PMCS_MODE_SUBSLEEP 3'h3
`define PMCS_MODE_STANDBY 3'h4
// Standby wait counts in states
`define PMCS_WAIT_8K 18'h02000
`define PMCS_WAIT_16K 18'h04000
`define PMCS_WAIT_32K 18'h08000
`define PMCS_WAIT_64K 18'h10000
`define PMCS_WAIT_128K 18'h20000
`define PMCS_WAIT_1K 18'h00400
`define PMCS_WAIT_128 18'h00080
`define PMCS_WAIT_16 18'h00010
// Noise filter sampling divide ratios minus one
`define PMCS_SAMPLE_DIV_SLOW 4'hf
`define PMCS_SAMPLE_DIV_FAST 4'h3
`endif

// ==== rtl/pmcs_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for one asynchronous level
module pmcs_sync (
    input wire clk, // System clock
    input wire rstn, // Async reset, active low
    input wire d, // Asynchronous input
    output reg q // Synchronised output
);
    reg meta; // First stage, read only by q

    // Only q looks at the first stage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== rtl/pmcs_div.v ====
`timescale 1ns/1ps
// Programmable divider giving a one-cycle enable every (limit+1) ticks
module pmcs_div (
    input wire clk, // System clock
    input wire rstn, // Async reset, active low
    input wire tick, // Count enable
    input wire [6:0] limit, // Terminal count, divide ratio minus one
    output reg pulse // One-cycle enable
);
    reg [6:0] cnt; // Running count

    // Restart from zero at terminal count; a new limit applies to the count in progress
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 7'h00;
            pulse <= 1'b0;
        end else if (tick) begin
            if (cnt >= limit) begin
                cnt <= 7'h00;
                pulse <= 1'b1;
            end else begin
                cnt <= cnt + 7'h01;
                pulse <= 1'b0;
            end
        end else begin
            pulse <= 1'b0;
        end
    end
endmodule

// ==== rtl/pmcs_top.v ====
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pmcs_regs.vh"
// Overview of operation
// - Sample rate bit picks osc/16 or osc/4
// - Control one bits 2..0 read zero
// - Wait code maps to documented state counts
// - Four bits jointly choose mode on sleep
// - Sleep, subsleep, standby or direct transition decode
// - Active divider: 0xx undivided, else 8..64
// - Divider changes apply only after sleep
// - Subclock divider: /8, /4, or /2
// - Control two fully read/write, reset zero
// - Wait applied on interrupt exit from standby or subsleep to active
module pmcs_top (
    input wire clk, // 40 MHz oscillator clock
    input wire rstn, // Async reset, active low
    input wire [3:0] avs_address, // Byte address
    input wire avs_read, // Read strobe
    input wire avs_write, // Write strobe
    input wire [31:0] avs_writedata, // Write data
    input wire [3:0] avs_byteenable, // Byte lanes
    output reg [31:0] avs_readdata, // Read data
    output reg avs_waitrequest, // Stall until answer ready
    input wire watch_clk_pin, // Asynchronous watch clock
    input wire sleep_exec, // One-cycle sleep instruction strobe
    input wire wake_irq, // Wake-up interrupt level
    output reg [2:0] power_mode, // Current operating mode
    output reg cpu_clk_en, // CPU clock enable pulse
    output reg periph_clk_en, // Peripheral clock enable pulse
    output reg watch_clk_filt, // Noise-filtered watch clock
    output reg osc_stopped // System oscillator halted
);
    // Software registers
    reg [7:0] power_mode_control_one; // Mode and wait control
    reg [7:0] power_mode_control_two; // Transition and dividers
    // Dividers latched at sleep time
    reg [2:0] act_div_live; // Applied active divider
    reg [1:0] sub_div_live; // Applied subclock divider
    // Wake-up wait state
    reg [17:0] wait_cnt; // Remaining settling states
    reg waiting; // Clocks gated during settle
    reg [2:0] return_mode; // Mode after settle
    // Watch clock path
    wire watch_sync; // Synchronised watch clock
    wire sample_pulse; // Noise filter sample strobe
    wire act_pulse; // Active clock enable
    wire sub_pulse; // Subclock enable
    reg [1:0] filt_hist; // Last two filter samples
    reg watch_prev; // For subclock edge detect
    wire watch_rise; // Filtered watch rising edge
    reg bus_ack; // Access answered this cycle
    reg [6:0] act_limit; // Active divide minus one
    reg [6:0] sub_limit; // Subclock divide minus one
    reg [6:0] samp_limit; // Sample divide minus one
    reg [17:0] wait_len; // Decoded wait length
    reg [7:0] wmask_one; // Writable-bit mask for control one
    reg [7:0] next_one; // Next control one value
    reg [7:0] next_two; // Next control two value
    reg [2:0] next_mode; // Mode chosen on sleep

    // Writes land on the acknowledge edge, the one the master completes on
    wire wr_one = avs_write && bus_ack &&
        avs_address == `PMCS_ADDR_CTRL_ONE && avs_byteenable[0];
    wire wr_two = avs_write && bus_ack &&
        avs_address == `PMCS_ADDR_CTRL_TWO && avs_byteenable[0];
    wire sleep_sw = avs_write && bus_ack &&
        avs_address == `PMCS_ADDR_SLEEP_CMD && avs_byteenable[0] &&
        avs_writedata[0];
    wire sleep_go = (sleep_exec || sleep_sw) && !waiting;

    pmcs_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .d(watch_clk_pin),
        .q(watch_sync)
    );

    // Watch clock sampler
    pmcs_div u_samp (
        .clk(clk),
        .rstn(rstn),
        .tick(1'b1),
        .limit(samp_limit),
        .pulse(sample_pulse)
    );

    // System clock divider for active and sleep
    pmcs_div u_act (
        .clk(clk),
        .rstn(rstn),
        .tick(1'b1),
        .limit(act_limit),
        .pulse(act_pulse)
    );

    // Subclock divider counts filtered watch edges
    pmcs_div u_sub (
        .clk(clk),
        .rstn(rstn),
        .tick(watch_rise),
        .limit(sub_limit),
        .pulse(sub_pulse)
    );

    assign watch_rise = watch_clk_filt && !watch_prev;

    // Decodes of fields into divide ratios and wait length
    always @* begin
        // Sampling rate select
        if (power_mode_control_one[`PMCS_SAMPLE_RATE_BIT]) begin
            samp_limit = {3'h0, `PMCS_SAMPLE_DIV_FAST};
        end else begin
            samp_limit = {3'h0, `PMCS_SAMPLE_DIV_SLOW};
        end
        // Active divider uses the value latched at sleep
        case (act_div_live)
            3'h4: act_limit = 7'h07;
            3'h5: act_limit = 7'h0f;
            3'h6: act_limit = 7'h1f;
            3'h7: act_limit = 7'h3f;
            default: act_limit = 7'h00;
        endcase
        // Subclock divider from watch clock
        case (sub_div_live)
            2'h0: sub_limit = 7'h07;
            2'h1: sub_limit = 7'h03;
            default: sub_limit = 7'h01;
        endcase
        // Standby wait length in states
        case (power_mode_control_one[`PMCS_WAIT_HI_BIT:`PMCS_WAIT_LO_BIT])
            3'h0: wait_len = `PMCS_WAIT_8K;
            3'h1: wait_len = `PMCS_WAIT_16K;
            3'h2: wait_len = `PMCS_WAIT_32K;
            3'h3: wait_len = `PMCS_WAIT_64K;
            3'h4: wait_len = `PMCS_WAIT_128K;
            3'h5: wait_len = `PMCS_WAIT_1K;
            3'h6: wait_len = `PMCS_WAIT_128;
            default: wait_len = `PMCS_WAIT_16;
        endcase
    end

    // Register write merge; reserved bits never stored
    always @* begin
        wmask_one = `PMCS_ONE_WMASK;
        next_one = (power_mode_control_one & ~wmask_one) |
            (avs_writedata[7:0] & wmask_one);
        next_two = avs_writedata[7:0];
    end

    // Mode chosen when a sleep instruction executes
    always @* begin
        next_mode = power_mode;
        if (power_mode_control_two[`PMCS_DIRECT_BIT]) begin
            if (power_mode_control_two[`PMCS_LOW_SPEED_BIT]) begin
                next_mode = `PMCS_MODE_SUBACTIVE;
            end else begin
                next_mode = `PMCS_MODE_ACTIVE;
            end
        end else if (power_mode_control_one[`PMCS_STBY_SEL_BIT]) begin
            next_mode = `PMCS_MODE_STANDBY;
        end else if (power_mode_control_two[`PMCS_SLEEP_KIND_BIT]) begin
            next_mode = `PMCS_MODE_SUBSLEEP;
        end else begin
            next_mode = `PMCS_MODE_SLEEP;
        end
    end

    // Avalon slave: one wait cycle, then acknowledge
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus_ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            power_mode_control_one <= `PMCS_ONE_RESET;
            power_mode_control_two <= `PMCS_TWO_RESET;
        end else begin
            bus_ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            if ((avs_read || avs_write) && !bus_ack) begin
                // Answer next cycle; waitrequest low for one edge
                bus_ack <= 1'b1;
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    `PMCS_ADDR_CTRL_ONE:
                        avs_readdata <= {24'h000000,
                            power_mode_control_one & `PMCS_ONE_WMASK};
                    `PMCS_ADDR_CTRL_TWO:
                        avs_readdata <= {24'h000000,
                            power_mode_control_two};
                    `PMCS_ADDR_STATUS:
                        avs_readdata <= {24'h000000, waiting,
                            osc_stopped, 1'b0, act_div_live,
                            sub_div_live};
                    default:
                        avs_readdata <= 32'h00000000;
                endcase
            end
            if (wr_one) begin
                power_mode_control_one <= next_one;
            end
            if (wr_two) begin
                power_mode_control_two <= next_two;
            end
        end
    end

    // Mode sequencer, divider latch and wake-up wait
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_mode <= `PMCS_MODE_ACTIVE;
            act_div_live <= 3'h0;
            sub_div_live <= 2'h0;
            waiting <= 1'b0;
            wait_cnt <= 18'h00000;
            return_mode <= `PMCS_MODE_ACTIVE;
            osc_stopped <= 1'b0;
        end else if (waiting) begin
            // Count settling states before releasing clocks
            if (wait_cnt <= 18'h00001) begin
                waiting <= 1'b0;
                power_mode <= return_mode;
            end else begin
                wait_cnt <= wait_cnt - 18'h00001;
            end
        end else if (sleep_go) begin
            // Dividers take effect only now, never on the write
            act_div_live <= power_mode_control_two[
                `PMCS_ACT_DIV_HI_BIT:`PMCS_ACT_DIV_LO_BIT];
            sub_div_live <= power_mode_control_two[
                `PMCS_SUB_DIV_HI_BIT:`PMCS_SUB_DIV_LO_BIT];
            power_mode <= next_mode;
            osc_stopped <= next_mode == `PMCS_MODE_STANDBY ||
                next_mode == `PMCS_MODE_SUBACTIVE ||
                next_mode == `PMCS_MODE_SUBSLEEP;
        end else if (wake_irq) begin
            case (power_mode)
                `PMCS_MODE_SLEEP: begin
                    power_mode <= `PMCS_MODE_ACTIVE;
                end
                `PMCS_MODE_STANDBY, `PMCS_MODE_SUBSLEEP: begin
                    // Oscillator restarts and clocks hold for settle time, except subsleep to subactive
                    waiting <= 1'b1;
                    wait_cnt <= wait_len;
                    osc_stopped <= 1'b0;
                    if (power_mode_control_two[`PMCS_LOW_SPEED_BIT] &&
                        power_mode == `PMCS_MODE_SUBSLEEP) begin
                        waiting <= 1'b0;
                        osc_stopped <= 1'b1;
                        power_mode <= `PMCS_MODE_SUBACTIVE;
                    end else begin
                        return_mode <= `PMCS_MODE_ACTIVE;
                    end
                end
                default: begin
                    power_mode <= power_mode;
                end
            endcase
        end
    end

    // Noise filter: accept watch level after two equal samples
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filt_hist <= 2'h0;
            watch_clk_filt <= 1'b0;
            watch_prev <= 1'b0;
        end else begin
            watch_prev <= watch_clk_filt;
            if (sample_pulse) begin
                filt_hist <= {filt_hist[0], watch_sync};
                if (filt_hist[0] == watch_sync) begin
                    watch_clk_filt <= watch_sync;
                end
            end
        end
    end

    // Clock enables; sleep modes stop the CPU, standby stops all
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
        end else if (waiting) begin
            cpu_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
        end else begin
            case (power_mode)
                `PMCS_MODE_ACTIVE: begin
                    cpu_clk_en <= act_pulse;
                    periph_clk_en <= act_pulse;
                end
                `PMCS_MODE_SLEEP: begin
                    cpu_clk_en <= 1'b0;
                    periph_clk_en <= act_pulse;
                end
                `PMCS_MODE_SUBACTIVE: begin
                    cpu_clk_en <= sub_pulse;
                    periph_clk_en <= sub_pulse;
                end
                `PMCS_MODE_SUBSLEEP: begin
                    cpu_clk_en <= 1'b0;
                    periph_clk_en <= sub_pulse;
                end
                default: begin
                    cpu_clk_en <= 1'b0;
                    periph_clk_en <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== test/pmcs_assertions.sv ====
`timescale 1ns/1ps
`include "pmcs_regs.vh"
// Port checks for the power mode and clock select block
module pmcs_assertions (
    input wire clk, // Clock
    input wire rstn, // Reset, active low
    input wire [3:0] avs_address, // Address
    input wire avs_read, // Read
    input wire avs_write, // Write
    input wire [31:0] avs_writedata, // Write data
    input wire [3:0] avs_byteenable, // Lanes
    input wire [31:0] avs_readdata, // Read data
    input wire avs_waitrequest, // Stall
    input wire watch_clk_pin, // Watch clock
    input wire sleep_exec, // Sleep strobe
    input wire wake_irq, // Wake request
    input wire [2:0] power_mode, // Mode
    input wire cpu_clk_en, // CPU enable
    input wire periph_clk_en, // Peripheral enable
    input wire watch_clk_filt, // Filtered watch clock
    input wire osc_stopped // Oscillator halted
);
    reg [7:0] sh_one; // Last byte landed in control one
    reg [7:0] sh_two; // Last byte landed in control two
    wire take = avs_write && !avs_waitrequest && avs_byteenable[0]; // Landed
    wire go = sleep_exec && power_mode == `PMCS_MODE_ACTIVE; // Sleep issued
    // Shadows let the mode checks see the fields without peeking inside
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_one <= 8'h00;
            sh_two <= 8'h00;
        end else if (take && avs_address == `PMCS_ADDR_CTRL_ONE) begin
            sh_one <= avs_writedata[7:0];
        end else if (take && avs_address == `PMCS_ADDR_CTRL_TWO) begin
            sh_two <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_req;
        $rose(avs_read) || $rose(avs_write);
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_ack;
        s_req |=> s_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer late or long");
    property p_one_rd;
        avs_read && !avs_waitrequest && avs_address == `PMCS_ADDR_CTRL_ONE
        |-> avs_readdata[7:0] == {sh_one[7:3], 3'h0};
    endproperty
    a_one_rd: assert property (p_one_rd) else $error("control one bad");
    property p_two_rd;
        avs_read && !avs_waitrequest && avs_address == `PMCS_ADDR_CTRL_TWO
        |-> avs_readdata[7:0] == sh_two;
    endproperty
    a_two_rd: assert property (p_two_rd) else $error("control two bad");
    property p_sleep;
        go && !sh_two[5] && !sh_one[7] |=> power_mode ==
            (sh_two[7] ? `PMCS_MODE_SUBSLEEP : `PMCS_MODE_SLEEP);
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep kind wrong");
    property p_stby;
        go && !sh_two[5] && sh_one[7]
        |=> power_mode == `PMCS_MODE_STANDBY && osc_stopped;
    endproperty
    a_stby: assert property (p_stby) else $error("standby not taken");
    property p_direct;
        go && sh_two[5] |=> power_mode ==
            (sh_two[6] ? `PMCS_MODE_SUBACTIVE : `PMCS_MODE_ACTIVE);
    endproperty
    a_direct: assert property (p_direct) else $error("direct wrong");
    property p_sleep_cpu;
        power_mode == `PMCS_MODE_SLEEP && $past(power_mode, 2) ==
            `PMCS_MODE_SLEEP |-> !cpu_clk_en;
    endproperty
    a_sleep_cpu: assert property (p_sleep_cpu) else $error("cpu runs");
    sequence s_off;
        (!cpu_clk_en && !periph_clk_en) [*8];
    endsequence
    property p_hold;
        power_mode == `PMCS_MODE_STANDBY && osc_stopped && wake_irq
        |=> s_off;
    endproperty
    a_hold: assert property (p_hold) else $error("clocks run in wait");
    property p_osc_run;
        power_mode == `PMCS_MODE_ACTIVE || power_mode == `PMCS_MODE_SLEEP
        |-> !osc_stopped;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("osc off");
endmodule
bind pmcs_top pmcs_assertions chk_u (.clk(clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .watch_clk_pin(watch_clk_pin), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .power_mode(power_mode), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .watch_clk_filt(watch_clk_filt),
    .osc_stopped(osc_stopped));

// ==== test/pmcs_top_tb.sv ====
`timescale 1ns/1ps
`include "pmcs_regs.vh"
// Register, mode and divider tests for the power mode block
module pmcs_top_tb;
    logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0; // Bus controls
    logic [3:0] avs_address = 0, avs_byteenable = 0; // Address and lanes
    logic [31:0] avs_writedata = 0, avs_readdata, q; // Data
    logic avs_waitrequest, watch_clk_pin = 0, sleep_exec = 0, wake_irq = 0;
    logic [2:0] power_mode; // Mode seen
    logic cpu_clk_en, periph_clk_en, watch_clk_filt, osc_stopped;
    logic [5:0] wcnt = 0; // Watch clock phase, 128 cycles a period
    int miscompares = 0, comparisons = 0, n, c, prev, k, code;
    logic [7:0] t_one [6] = '{8'h70, 8'h70, 8'hf0, 8'he0, 8'h70, 8'h70};
    logic [7:0] t_two [6] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h20, 8'h60};
    logic [2:0] t_mode [6] = '{1, 3, 4, 4, 0, 2}; // Expected modes
    int t_wait [6] = '{0, 16, 16, 128, 0, 0}; // Expected settling wait
    pmcs_top dut_u (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .watch_clk_pin(watch_clk_pin), .sleep_exec(sleep_exec),
        .wake_irq(wake_irq), .power_mode(power_mode),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .watch_clk_filt(watch_clk_filt), .osc_stopped(osc_stopped));
    // Free clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Slow watch clock, slow enough for the filter to pass at either rate
    always @(posedge clk) begin
        wcnt <= wcnt + 6'h01;
        if (wcnt == 6'h3f) begin
            watch_clk_pin <= ~watch_clk_pin;
        end
    end
    // Report verdict and end
    task stop_test;
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
             input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        // Only the watchdog ends a stuck wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Count CPU clock enables over a window
    task cnt(input int len);
        c = 0;
        repeat (len) begin
            @(posedge clk);
            if (cpu_clk_en === 1'b1) c++;
        end
    endtask
    // One-cycle sleep instruction
    task sleep;
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait for a mode
    task wait_mode(input logic [2:0] m);
        n = 0;
        while (power_mode !== m && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask
    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        stop_test;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        bus(0, 4'h0, 0, 4'hf); chk(q, 0);
        bus(0, 4'h4, 0, 4'hf); chk(q, 0);
        bus(1, 4'h0, 8'hff, 4'hf); bus(0, 4'h0, 0, 4'hf); chk(q, 8'hf8);
        bus(1, 4'h4, 8'hff, 4'hf); bus(0, 4'h4, 0, 4'hf); chk(q, 8'hff);
        bus(1, 4'h4, 8'h00, 4'he); bus(0, 4'h4, 0, 4'hf); chk(q, 8'hff);
        bus(1, 4'h4, 8'h00, 4'hf); bus(0, 4'h4, 0, 4'hf); chk(q, 0);
        bus(1, 4'h2, 8'hff, 4'hf); bus(0, 4'h2, 0, 4'hf); chk(q, 0);
        bus(0, 4'h8, 0, 4'hf); chk(q, 0);
        // Mode decode and wake-up waits
        for (k = 0; k < 6; k++) begin
            bus(1, 4'h0, t_one[k], 4'hf);
            bus(1, 4'h4, t_two[k], 4'hf);
            sleep;
            chk(power_mode, t_mode[k]);
            chk(osc_stopped, t_mode[k] >= 2);
            // Enables follow the new mode one edge later
            @(posedge clk);
            if (t_mode[k] != 2) chk(cpu_clk_en, t_mode[k] == 0);
            if (t_mode[k] != 2 && t_mode[k] != 3)
                chk(periph_clk_en, t_mode[k] < 2);
            if (t_mode[k] == 2) begin
                bus(1, 4'h4, 8'h20, 4'hf);
                sleep;
            end else if (t_mode[k] != 0) begin
                @(posedge clk);
                wake_irq <= 1'b1;
            end
            wait_mode(`PMCS_MODE_ACTIVE);
            wake_irq <= 1'b0;
            chk(power_mode, `PMCS_MODE_ACTIVE);
            if (t_wait[k] != 0) chk(n > t_wait[k] && n <= t_wait[k] + 3, 1);
        end
        // Active divider applies only after sleep
        prev = 128;
        for (k = 0; k < 5; k++) begin
            code = (k < 4) ? 4 + k : 1;
            bus(1, 4'h4, 8'h20 | (code << 2), 4'hf);
            cnt(128); chk(c, prev);
            sleep;
            repeat (4) @(posedge clk);
            bus(0, 4'h8, 0, 4'hf); chk(q, code << 2);
            prev = (code < 4) ? 128 : 128 >> (code - 1);
            cnt(128); chk(c, prev);
        end
        // Subclock divider in subactive mode
        for (k = 0; k < 4; k++) begin
            bus(1, 4'h4, 8'h60 | k, 4'hf);
            if (k > 0) begin
                cnt(2048); chk(c, prev);
            end
            sleep;
            repeat (300) @(posedge clk);
            prev = (k == 0) ? 2 : (k == 1) ? 4 : 8;
            cnt(2048); chk(c, prev);
        end
        bus(1, 4'h4, 8'h20, 4'hf);
        // Sleep through the command register this time
        bus(1, 4'hc, 8'h01, 4'hf);
        wait_mode(`PMCS_MODE_ACTIVE);
        chk(power_mode, `PMCS_MODE_ACTIVE);
        // Filter lag at both sample rates
        for (k = 1; k >= 0; k--) begin
            bus(1, 4'h0, k << 3, 4'hf);
            while (wcnt != 0) @(posedge clk);
            wait_mode(power_mode);
            while (watch_clk_filt !== watch_clk_pin && n < 100) begin
                @(posedge clk);
                n++;
            end
            chk(k ? n <= 13 : n >= 16 && n <= 40, 1);
        end
        stop_test;
    end
endmodule
